// ==== src/asf_pkg.sv ====
package asf_pkg;
	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_CHEN = 8'h10;
	localparam logic [7:0] OFF_CHDIS = 8'h14;
	localparam logic [7:0] OFF_CHSR = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_LAST = 8'h20;
	localparam logic [7:0] OFF_CHRES0 = 8'h30;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_START_BIT = 1;
	localparam int MODE_SLEEP_BIT = 5;
	localparam int ST_OVR_POS = 8;
	localparam int ST_DATA_READY_FLAG_POS = 16;
	localparam int ST_GOVR_POS = 17;
	localparam int ST_SLEEP_POS = 18;
	localparam int ST_BUSY_POS = 19;
	localparam int LAST_CH_POS = 12;
	// ---------------------------------------------------------------
	// Reset values and timing
	// ---------------------------------------------------------------
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam int CONV_NS = 40;
	localparam int CLK_MHZ = 250;
	localparam int CONV_CYCLES = (CONV_NS * CLK_MHZ + 999) / 1000;
endpackage : asf_pkg

// ==== src/asf_status_flags.sv ====
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module asf_status_flags #(
	parameter int NCH = 8,
	parameter int RES_W = 10,
	parameter int CONV_CYC = asf_pkg::CONV_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [RES_W-1:0] conv_result,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic conv_sleep
);
	// ---------------------------------------------------------------
	// Types and state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_SLEEP} asf_state_e;

	asf_state_e state_reg, state_next;
	logic [NCH-1:0] chen_reg, chen_next;
	logic [NCH-1:0] done_reg, done_next;
	logic [NCH-1:0] ovr_reg, ovr_next;
	logic [NCH-1:0] pend_reg, pend_next;
	logic [$clog2(NCH)-1:0] cur_reg, cur_next;
	logic [$clog2(NCH)-1:0] lastch_reg, lastch_next;
	logic [RES_W-1:0] res_reg [NCH];
	logic [RES_W-1:0] res_next [NCH];
	logic [RES_W-1:0] last_reg, last_next;
	logic data_ready_flag_reg, data_ready_flag_next;
	logic govr_reg, govr_next;
	logic sleep_reg, sleep_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [31:0] prdata_next;
	logic pready_next, pslverr_next;

	logic acc, wr, rd, hit_res;
	logic [$clog2(NCH)-1:0] res_idx;
	logic eoc, eoc_en;
	logic [NCH-1:0] dis_mask;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	// One wait state: setup then access, pready is registered and rises one cycle into the access phase
	assign acc = psel && penable && !pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign hit_res = (paddr >= asf_pkg::OFF_CHRES0)
		&& (paddr < asf_pkg::OFF_CHRES0 + 8'(4 * NCH)) && (paddr[1:0] == 2'b00);
	assign res_idx = $clog2(NCH)'((paddr - asf_pkg::OFF_CHRES0) >> 2);
	assign dis_mask = (wr && paddr == asf_pkg::OFF_CHDIS) ? pwdata[NCH-1:0] : '0;
	assign eoc = (state_reg == ST_CONV) && (cnt_reg == 16'h0000);
	// Disable in the same cycle kills the event, so no flag or store follows
	assign eoc_en = eoc && chen_reg[cur_reg] && !dis_mask[cur_reg];

	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	logic wr_ctrl, wr_mode, wr_chen, wr_chdis, wr_bad;
	logic rd_mode, rd_chsr, rd_status, rd_last, rd_res, rd_bad;
	logic start_cmd;

	assign wr_ctrl = wr && (paddr == asf_pkg::OFF_CTRL);
	assign wr_mode = wr && (paddr == asf_pkg::OFF_MODE);
	assign wr_chen = wr && (paddr == asf_pkg::OFF_CHEN);
	assign wr_chdis = wr && (paddr == asf_pkg::OFF_CHDIS);
	assign wr_bad = wr && !wr_ctrl && !wr_mode && !wr_chen && !wr_chdis;
	assign rd_mode = rd && (paddr == asf_pkg::OFF_MODE);
	assign rd_chsr = rd && (paddr == asf_pkg::OFF_CHSR);
	assign rd_status = rd && (paddr == asf_pkg::OFF_STATUS);
	assign rd_last = rd && (paddr == asf_pkg::OFF_LAST);
	assign rd_res = rd && hit_res;
	// Control, enable and disable read back as zero without an error
	assign rd_bad = rd && !rd_mode && !rd_chsr && !rd_status && !rd_last && !hit_res
		&& (paddr != asf_pkg::OFF_CTRL) && (paddr != asf_pkg::OFF_CHEN)
		&& (paddr != asf_pkg::OFF_CHDIS);
	// A start with no channel enabled is dropped, nothing to convert
	assign start_cmd = wr_ctrl && pwdata[asf_pkg::CTRL_START_BIT] && (chen_reg != '0);

	// ---------------------------------------------------------------
	// Configuration
	// ---------------------------------------------------------------
	always_comb begin
		chen_next = chen_reg;
		sleep_next = sleep_reg;
		if (wr_mode) begin
			sleep_next = pwdata[asf_pkg::MODE_SLEEP_BIT];
		end else if (wr_chen) begin
			chen_next = chen_reg | pwdata[NCH-1:0];
		end else if (wr_chdis) begin
			chen_next = chen_reg & ~pwdata[NCH-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chen_reg <= '0;
			sleep_reg <= asf_pkg::MODE_RST[asf_pkg::MODE_SLEEP_BIT];
		end else begin
			chen_reg <= chen_next;
			sleep_reg <= sleep_next;
		end
	end

	// ---------------------------------------------------------------
	// Conversion sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		pend_next = pend_reg;
		cur_next = cur_reg;
		cnt_next = cnt_reg;
		if (start_cmd) begin
			pend_next = chen_reg;
			if (state_reg == ST_SLEEP)
				state_next = ST_IDLE;
		end else if (wr_chdis) begin
			// Queued channels that get disabled never start, except one picked in this same idle cycle, which converts but stores nothing
			pend_next = pend_reg & ~pwdata[NCH-1:0];
		end
		case (state_reg)
			ST_IDLE: begin
				if (pend_reg != '0) begin
					state_next = ST_CONV;
					cnt_next = 16'(CONV_CYC - 1);
					for (int i = NCH - 1; i >= 0; i--) begin
						if (pend_reg[i])
							cur_next = $clog2(NCH)'(i);
					end
				end
			end
			ST_CONV: begin
				if (cnt_reg != 16'h0000) begin
					cnt_next = cnt_reg - 16'h0001;
				end else begin
					pend_next[cur_reg] = 1'b0;
					if (pend_next == '0 && sleep_next)
						state_next = ST_SLEEP;
					else
						state_next = ST_IDLE;
				end
			end
			ST_SLEEP: begin
				// Left only by a start command
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			pend_reg <= '0;
			cur_reg <= '0;
			cnt_reg <= 16'h0000;
			conv_sleep <= 1'b0;
		end else begin
			state_reg <= state_next;
			pend_reg <= pend_next;
			cur_reg <= cur_next;
			cnt_reg <= cnt_next;
			conv_sleep <= (state_next == ST_SLEEP);
		end
	end

	// ---------------------------------------------------------------
	// Status flags
	// ---------------------------------------------------------------
	always_comb begin
		done_next = done_reg;
		ovr_next = ovr_reg;
		data_ready_flag_next = data_ready_flag_reg;
		govr_next = govr_reg;
		if (rd_status) begin
			ovr_next = '0;
			govr_next = 1'b0;
		end else if (rd_last) begin
			data_ready_flag_next = 1'b0;
			done_next[lastch_reg] = 1'b0;
		end else if (rd_res) begin
			// Data-ready untouched here, only the one done bit drops
			done_next[res_idx] = 1'b0;
		end
		// Setting events come last so they win over same-cycle clears
		if (eoc_en) begin
			data_ready_flag_next = 1'b1;
			if (data_ready_flag_reg)
				govr_next = 1'b1;
			if (done_reg[cur_reg])
				ovr_next[cur_reg] = 1'b1;
			done_next[cur_reg] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= '0;
			ovr_reg <= '0;
			data_ready_flag_reg <= 1'b0;
			govr_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
			ovr_reg <= ovr_next;
			data_ready_flag_reg <= data_ready_flag_next;
			govr_reg <= govr_next;
		end
	end

	// ---------------------------------------------------------------
	// Result storage
	// ---------------------------------------------------------------
	always_comb begin
		res_next = res_reg;
		last_next = last_reg;
		lastch_next = lastch_reg;
		if (eoc_en) begin
			res_next[cur_reg] = conv_result;
			last_next = conv_result;
			lastch_next = cur_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NCH; i++)
				res_reg[i] <= '0;
			last_reg <= '0;
			lastch_reg <= '0;
		end else begin
			res_reg <= res_next;
			last_reg <= last_next;
			lastch_reg <= lastch_next;
		end
	end

	// ---------------------------------------------------------------
	// Read data and response
	// ---------------------------------------------------------------
	always_comb begin
		prdata_next = 32'h0000_0000;
		pready_next = acc;
		pslverr_next = wr_bad || rd_bad;
		if (rd_mode) begin
			prdata_next[asf_pkg::MODE_SLEEP_BIT] = sleep_reg;
		end else if (rd_chsr) begin
			prdata_next[NCH-1:0] = chen_reg;
		end else if (rd_status) begin
			prdata_next[NCH-1:0] = done_reg;
			prdata_next[asf_pkg::ST_OVR_POS +: NCH] = ovr_reg;
			prdata_next[asf_pkg::ST_DATA_READY_FLAG_POS] = data_ready_flag_reg;
			prdata_next[asf_pkg::ST_GOVR_POS] = govr_reg;
			prdata_next[asf_pkg::ST_SLEEP_POS] = (state_reg == ST_SLEEP);
			prdata_next[asf_pkg::ST_BUSY_POS] = (state_reg == ST_CONV);
		end else if (rd_last) begin
			prdata_next[RES_W-1:0] = last_reg;
			prdata_next[asf_pkg::LAST_CH_POS +: $clog2(NCH)] = lastch_reg;
		end else if (rd_res) begin
			prdata_next[RES_W-1:0] = res_reg[res_idx];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end
endmodule : asf_status_flags
`default_nettype wire

// ==== verification/asf_status_flags_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module asf_chk #(
	parameter int NCH = 8,
	parameter int RES_W = 10,
	parameter int CONV_CYC = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [RES_W-1:0] conv_result,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic conv_sleep
);
	logic tk;
	logic [7:0] en_reg, en_next, age_reg, age_next;
	assign tk = psel && penable && !pready;
	// Age saturates so a long idle spell cannot wrap back to a small count
	always_comb begin
		en_next = en_reg;
		age_next = age_reg + {7'h00, age_reg != 8'hff};
		if (tk && pwrite && paddr == asf_pkg::OFF_CHEN) en_next = en_reg | pwdata[7:0];
		if (tk && pwrite && paddr == asf_pkg::OFF_CHDIS) en_next = en_reg & ~pwdata[7:0];
		if (tk && pwrite && paddr == asf_pkg::OFF_CTRL && pwdata[1]) age_next = 8'h00;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= 8'h00;
			age_reg <= 8'h00;
		end else begin
			en_reg <= en_next;
			age_reg <= age_next;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence rd_s; tk && !pwrite; endsequence
	sequence wr_s; tk && pwrite; endsequence
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
	ready_answer_a: assert property (tk |=> pready) else $error("no ready");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	unmapped_err_a: assert property (tk && paddr == 8'h08 |=> pslverr) else $error("no error");
	status_ro_a: assert property (wr_s ##0 paddr == asf_pkg::OFF_STATUS |=> pslverr)
		else $error("status write taken");
	enable_mask_a: assert property (rd_s ##0 paddr == asf_pkg::OFF_CHSR |=> prdata[7:0] == en_reg)
		else $error("enable mask wrong");
	start_wakes_a: assert property (wr_s ##0 paddr == asf_pkg::OFF_CTRL && pwdata[1] |=> !conv_sleep)
		else $error("sleep kept after start");
	sleep_late_a: assert property ($rose(conv_sleep) |-> int'(age_reg) >= CONV_CYC - 1)
		else $error("sleep before conversion end");
endmodule : asf_chk
bind asf_status_flags asf_chk #(.NCH(NCH), .RES_W(RES_W), .CONV_CYC(CONV_CYC)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .conv_result(conv_result), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .conv_sleep(conv_sleep)
);
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, conv_sleep;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, lf = 32'hc862fd87;
	logic [9:0] conv_result = 10'h000, v;
	logic [32:0] exp_q[$], msk_q[$];
	int fail_count = 0, checks_done = 0;
	localparam int W = 2 * asf_pkg::CONV_CYCLES + 8;
	localparam logic [7:0] ST = asf_pkg::OFF_STATUS;
	localparam logic [32:0] ERR = 33'h1_0000_0000;
	asf_status_flags uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .conv_result(conv_result),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_sleep(conv_sleep));
	always #2 pclk = ~pclk;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic test_done;
		if (fail_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic chk(input logic [32:0] e, m, g);
		checks_done++;
		if (((g ^ e) & m) !== 33'h0) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	always @(posedge pclk) if (pready === 1'b1) chk(exp_q.pop_front(), msk_q.pop_front(), {pslverr, prdata});
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e, m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0, ERR);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
	endtask : rd
	// One fixed result per sequence, so stored data is predictable
	task automatic run(input int n);
		v = lf[9:0];
		lf = lfsr(lf);
		conv_result <= v;
		wr(asf_pkg::OFF_CTRL, 32'h2);
		repeat (n) @(posedge pclk);
	endtask : run
	initial begin
		repeat (3000) @(posedge pclk);
		fail_count++;
		test_done();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(asf_pkg::OFF_MODE, asf_pkg::MODE_RST, 32'hffffffff);
		apb(1'b0, 8'h08, 32'h0, ERR, ERR);
		apb(1'b1, ST, 32'h0, ERR, ERR);
		wr(asf_pkg::OFF_CHEN, 32'h3);
		rd(asf_pkg::OFF_CHSR, 32'h3, 32'hff);
		run(W);
		rd(ST, 32'h3_0003, 32'h3_ffff);
		rd(ST, 32'h1_0003, 32'h3_ffff);
		rd(asf_pkg::OFF_CHRES0, {22'h0, v}, 32'h3ff);
		rd(ST, 32'h1_0002, 32'h3_ffff);
		rd(asf_pkg::OFF_LAST, {17'h0, 3'h1, 2'h0, v}, 32'h73ff);
		rd(ST, 32'h0, 32'h3_ffff);
		run(W);
		run(W);
		rd(ST, 32'h3_0303, 32'h3_ffff);
		rd(ST, 32'h1_0003, 32'h3_ffff);
		rd(asf_pkg::OFF_LAST, {17'h0, 3'h1, 2'h0, v}, 32'h73ff);
		wr(asf_pkg::OFF_MODE, 32'h20);
		rd(ST, 32'h0, 32'h4_0000);
		run(14);
		wr(asf_pkg::OFF_CHDIS, 32'h2);
		repeat (W) @(posedge pclk);
		rd(ST, 32'h4_0000, 32'h4_0002);
		chk(33'h1, 33'h1, {32'h0, conv_sleep});
		test_done();
	end
endmodule : testbench
`default_nettype wire
